//--- src/mpt_top.sv
// Behaviour
// - run alone gives free 50% square wave
// - square-wave counter ticks on instruction clock
// - setting run loads reload value, starts count
// - square underflow inverts pin, counting reloads
// - square wave runs until run bit cleared
// - mid bit selects variable duty, instruction clock
// - main timer underflow sets run, pin high
// - counter underflow clears run, pin low
// - high bit selects burst, mid picks clock
// - reset clears mode bits, pin normal I/O
// - instruction clock is oscillator divided by ten
// - burst passes pulses, underflow stops, pin low
`timescale 1ns/1ps
`default_nettype none

module mpt_top (
	input  wire logic       CLK_IN,
	input  wire logic       SYS_RST_IN,
	input  wire logic       CTRL_WR_IN,
	input  wire logic [2:0] CTRL_WDATA_IN,
	input  wire logic       RELOAD_WR_IN,
	input  wire logic [7:0] RELOAD_WDATA_IN,
	input  wire logic       TIMER_UFL_IN,
	input  wire logic       PORT_DATA_IN,
	output var  logic       PULSE_PIN_OUT,
	output var  logic       RUN_BIT_OUT,
	output var  logic       MODE_MID_OUT,
	output var  logic       MODE_HIGH_OUT,
	output var  logic [7:0] COUNT_OUT
);

	logic       run_reg;
	logic       run_next;
	logic       mid_reg;
	logic       mid_next;
	logic       high_reg;
	logic       high_next;
	logic [7:0] reload_reg;
	logic [7:0] reload_next;
	logic [7:0] count_reg;
	logic [7:0] count_next;
	logic       pin_reg;
	logic       pin_next;
	logic       osc_ph_reg;
	logic       osc_ph_next;
	logic       tc_tick;
	logic       tc_high;
	logic       burst_tick;
	logic       at_zero;
	mpt_pkg::mpt_mode_t mode;

	function automatic mpt_pkg::mpt_mode_t mode_of(input logic high, input logic mid, input logic run);
		if (high) begin
			return mpt_pkg::MPT_BURST;
		end else if (mid) begin
			return mpt_pkg::MPT_VARDUTY;
		end else if (run) begin
			return mpt_pkg::MPT_SQUARE;
		end else begin
			return mpt_pkg::MPT_IO;
		end
	endfunction : mode_of

	mpt_tc_div u_tc_div (
		.clk_in   (CLK_IN),
		.rst_in   (SYS_RST_IN),
		.tick_out (tc_tick),
		.high_out (tc_high)
	);

	assign mode       = mode_of(high_reg, mid_reg, run_reg);
	assign at_zero    = (count_reg == mpt_pkg::COUNT_ZERO);
	// osc clock shown at half rate: a flop cannot forward the clock itself
	assign burst_tick = mid_reg ? osc_ph_reg : tc_tick;

	always_comb begin
		run_next    = run_reg;
		mid_next    = mid_reg;
		high_next   = high_reg;
		reload_next = reload_reg;
		count_next  = count_reg;
		pin_next    = pin_reg;
		osc_ph_next = osc_ph_reg;
		if (RELOAD_WR_IN) begin
			reload_next = RELOAD_WDATA_IN;
		end
		unique case (mode)
			mpt_pkg::MPT_IO: begin
				pin_next = PORT_DATA_IN;
			end
			mpt_pkg::MPT_SQUARE: begin
				if (tc_tick) begin
					if (at_zero) begin
						count_next = reload_reg;
						pin_next   = ~pin_reg;
					end else begin
						count_next = count_reg - mpt_pkg::COUNT_STEP;
					end
				end
			end
			mpt_pkg::MPT_VARDUTY: begin
				if (run_reg && tc_tick) begin
					if (at_zero) begin
						run_next = 1'b0;
						pin_next = 1'b0;
					end else begin
						count_next = count_reg - mpt_pkg::COUNT_STEP;
					end
				end
			end
			mpt_pkg::MPT_BURST: begin
				if (run_reg) begin
					osc_ph_next = mid_reg ? ~osc_ph_reg : 1'b0;
					pin_next    = mid_reg ? osc_ph_reg : tc_high;
					if (burst_tick) begin
						if (at_zero) begin
							// stop after last pulse
							// on osc clock pin keeps this pulse, so n-1 loaded yields n pulses; on cycle clock the start phase gives n-1 or n
							run_next    = 1'b0;
							osc_ph_next = 1'b0;
						end else begin
							count_next = count_reg - mpt_pkg::COUNT_STEP;
						end
					end
				end else begin
					pin_next    = 1'b0;
					osc_ph_next = 1'b0;
				end
			end
		endcase
		// only software clear stops square mode
		// software write beats a same-cycle hardware stop
		if (CTRL_WR_IN) begin
			high_next = CTRL_WDATA_IN[mpt_pkg::CTL_HIGH_BIT];
			mid_next  = CTRL_WDATA_IN[mpt_pkg::CTL_MID_BIT];
			run_next  = CTRL_WDATA_IN[mpt_pkg::CTL_RUN_BIT];
			if (CTRL_WDATA_IN[mpt_pkg::CTL_RUN_BIT] && !run_reg) begin
				count_next  = reload_reg;
				pin_next    = 1'b0;
				osc_ph_next = 1'b0;
			end
		end
		if (TIMER_UFL_IN && high_next == 1'b0 && mid_next) begin
			run_next   = 1'b1;
			count_next = reload_reg;
			pin_next   = 1'b1;
		end
	end

	always_ff @(posedge CLK_IN) begin
		if (SYS_RST_IN) begin
			run_reg    <= mpt_pkg::CTL_RST[mpt_pkg::CTL_RUN_BIT];
			mid_reg    <= mpt_pkg::CTL_RST[mpt_pkg::CTL_MID_BIT];
			high_reg   <= mpt_pkg::CTL_RST[mpt_pkg::CTL_HIGH_BIT];
			reload_reg <= mpt_pkg::RELOAD_RST;
			count_reg  <= mpt_pkg::COUNT_RST;
			pin_reg    <= 1'b0;
			osc_ph_reg <= 1'b0;
		end else begin
			run_reg    <= run_next;
			mid_reg    <= mid_next;
			high_reg   <= high_next;
			reload_reg <= reload_next;
			count_reg  <= count_next;
			pin_reg    <= pin_next;
			osc_ph_reg <= osc_ph_next;
		end
	end

	assign PULSE_PIN_OUT = pin_reg;
	assign RUN_BIT_OUT   = run_reg;
	assign MODE_MID_OUT  = mid_reg;
	assign MODE_HIGH_OUT = high_reg;
	assign COUNT_OUT     = count_reg;

	a_reset_clear_bits: assert property (
		@(posedge CLK_IN) SYS_RST_IN |=> (!run_reg && !mid_reg && !high_reg)
	) else $error("mode bits not cleared by reset");

	a_io_pin_follow: assert property (
		@(posedge CLK_IN) disable iff (SYS_RST_IN)
		(mode == mpt_pkg::MPT_IO && !CTRL_WR_IN && !TIMER_UFL_IN) |=> (pin_reg == $past(PORT_DATA_IN))
	) else $error("pin does not follow port data in normal mode");

	a_start_load_count: assert property (
		@(posedge CLK_IN) disable iff (SYS_RST_IN)
		(CTRL_WR_IN && CTRL_WDATA_IN[0] && !CTRL_WDATA_IN[1] && !run_reg)
		|=> (run_reg && count_reg == $past(reload_reg))
	) else $error("counter not loaded from reload on start");

	a_square_toggle_pin: assert property (
		@(posedge CLK_IN) disable iff (SYS_RST_IN)
		(mode == mpt_pkg::MPT_SQUARE && tc_tick && at_zero && !CTRL_WR_IN && !TIMER_UFL_IN)
		|=> (pin_reg != $past(pin_reg) && count_reg == $past(reload_reg))
	) else $error("square wave missed toggle or reload");

	a_square_tc_only: assert property (
		@(posedge CLK_IN) disable iff (SYS_RST_IN)
		(mode == mpt_pkg::MPT_SQUARE && !tc_tick && !CTRL_WR_IN && !TIMER_UFL_IN)
		|=> ($stable(count_reg) && $stable(pin_reg))
	) else $error("square counter moved without instruction tick");

	a_square_keep_run: assert property (
		@(posedge CLK_IN) disable iff (SYS_RST_IN)
		(mode == mpt_pkg::MPT_SQUARE && !CTRL_WR_IN) |=> run_reg
	) else $error("square wave stopped by itself");

	a_tc_ten_period: assert property (
		@(posedge CLK_IN) disable iff (SYS_RST_IN)
		tc_tick |=> !tc_tick [*8] ##1 !tc_tick ##1 tc_tick
	) else $error("instruction clock period is not ten");

	a_vd_pulse_start: assert property (
		@(posedge CLK_IN) disable iff (SYS_RST_IN)
		(mode == mpt_pkg::MPT_VARDUTY && TIMER_UFL_IN && !CTRL_WR_IN)
		|=> (run_reg && pin_reg && count_reg == $past(reload_reg))
	) else $error("main timer underflow did not start pulse");

	a_vd_pulse_end: assert property (
		@(posedge CLK_IN) disable iff (SYS_RST_IN)
		(mode == mpt_pkg::MPT_VARDUTY && run_reg && tc_tick && at_zero && !TIMER_UFL_IN && !CTRL_WR_IN)
		|=> (!run_reg && !pin_reg) ##1 ($past(CTRL_WR_IN) || pin_reg == $past(TIMER_UFL_IN))
	) else $error("pulse did not end low on counter underflow");

	a_burst_stop_low: assert property (
		@(posedge CLK_IN) disable iff (SYS_RST_IN)
		(mode == mpt_pkg::MPT_BURST && run_reg && burst_tick && at_zero && !CTRL_WR_IN)
		|=> (!run_reg && pin_reg == $past(mid_reg)) ##1 !pin_reg
	) else $error("burst did not stop at underflow");

	a_burst_idle_low: assert property (
		@(posedge CLK_IN) disable iff (SYS_RST_IN)
		(mode == mpt_pkg::MPT_BURST && !run_reg && !CTRL_WR_IN) |=> !pin_reg
	) else $error("burst pin not low while stopped");

	a_burst_osc_clock: assert property (
		@(posedge CLK_IN) disable iff (SYS_RST_IN)
		(mode == mpt_pkg::MPT_BURST && mid_reg && run_reg && !at_zero && !CTRL_WR_IN)
		|=> (osc_ph_reg != $past(osc_ph_reg) && pin_reg == $past(osc_ph_reg))
	) else $error("oscillator burst not clocked every cycle");

	a_burst_tc_clock: assert property (
		@(posedge CLK_IN) disable iff (SYS_RST_IN)
		(mode == mpt_pkg::MPT_BURST && !mid_reg && run_reg && !tc_tick && !CTRL_WR_IN)
		|=> (pin_reg == $past(tc_high) && $stable(count_reg))
	) else $error("instruction-clock burst does not follow cycle clock");

endmodule : mpt_top

`default_nettype wire

//--- include/mpt_pkg.sv
package mpt_pkg;

	// instruction-cycle clock is the oscillator divided by this figure
	localparam logic [3:0] TC_DIV        = 4'ha;
	// cycles of each instruction period during which the cycle clock is high
	localparam logic [3:0] TC_HIGH       = 4'h5;
	localparam logic [3:0] TC_CNT_RST    = 4'h0;

	// bit positions of the control word written by software
	localparam int         CTL_RUN_BIT   = 0;
	localparam int         CTL_MID_BIT   = 1;
	localparam int         CTL_HIGH_BIT  = 2;
	localparam logic [2:0] CTL_RST       = 3'h0;

	localparam logic [7:0] RELOAD_RST    = 8'h00;
	localparam logic [7:0] COUNT_RST     = 8'h00;
	localparam logic [7:0] COUNT_ZERO    = 8'h00;
	localparam logic [7:0] COUNT_STEP    = 8'h01;

	typedef enum logic [1:0] {
		MPT_IO      = 2'b00,
		MPT_SQUARE  = 2'b01,
		MPT_VARDUTY = 2'b10,
		MPT_BURST   = 2'b11
	} mpt_mode_t;

endpackage : mpt_pkg

//--- src/mpt_tc_div.sv
`timescale 1ns/1ps
`default_nettype none

module mpt_tc_div (
	input  wire logic clk_in,
	input  wire logic rst_in,
	output var  logic tick_out,
	output var  logic high_out
);

	logic [3:0] cnt_reg;
	logic [3:0] cnt_next;
	logic       tick_next;
	logic       high_next;

	always_comb begin
		if (cnt_reg == mpt_pkg::TC_DIV - 4'h1) begin
			cnt_next = mpt_pkg::TC_CNT_RST;
		end else begin
			cnt_next = cnt_reg + 4'h1;
		end
		// tick marks the last oscillator cycle of each instruction period
		tick_next = (cnt_next == mpt_pkg::TC_DIV - 4'h1);
		high_next = (cnt_next < mpt_pkg::TC_HIGH);
	end

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			cnt_reg  <= mpt_pkg::TC_CNT_RST;
			tick_out <= 1'b0;
			high_out <= 1'b0;
		end else begin
			cnt_reg  <= cnt_next;
			tick_out <= tick_next;
			high_out <= high_next;
		end
	end

endmodule : mpt_tc_div

`default_nettype wire

//--- test/mpt_load_model.sv
`timescale 1ns/1ps
`default_nettype none

module mpt_load_model (
	input  wire logic        clk_in,
	input  wire logic        clr_in,
	input  wire logic        pin_in,
	output var  logic [15:0] rises_out
);
	logic prev_reg;

	always_ff @(posedge clk_in) begin
		prev_reg <= pin_in;
		if (clr_in) begin
			rises_out <= 16'h0000;
		end else if (pin_in && !prev_reg) begin
			rises_out <= rises_out + 16'h0001;
		end
	end
endmodule : mpt_load_model
`default_nettype wire

//--- test/tb.sv
`timescale 1ns/1ps
`default_nettype none

module tb;
	logic        clk, rst, ctl_wr, rl_wr, ufl, port, clr, pin, run, mid, high;
	logic [2:0]  ctl_d;
	logic [7:0]  rl_d, cnt;
	logic [15:0] seed, rises;
	int          mismatches, samples_checked, n, rl;

	mpt_top mpt_top_inst (.CLK_IN(clk), .SYS_RST_IN(rst), .CTRL_WR_IN(ctl_wr), .CTRL_WDATA_IN(ctl_d),
		.RELOAD_WR_IN(rl_wr), .RELOAD_WDATA_IN(rl_d), .TIMER_UFL_IN(ufl), .PORT_DATA_IN(port),
		.PULSE_PIN_OUT(pin), .RUN_BIT_OUT(run), .MODE_MID_OUT(mid), .MODE_HIGH_OUT(high), .COUNT_OUT(cnt));
	mpt_load_model mpt_load_model_inst (.clk_in(clk), .clr_in(clr), .pin_in(pin), .rises_out(rises));

	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction : lfsr

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		samples_checked++;
		if (got !== exp) begin
			mismatches++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic stop_test();
		$display("checked %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : stop_test

	// c selects control word, else reload value
	task automatic wr(input logic c, input logic [7:0] d);
		@(negedge clk);
		ctl_wr = c;
		rl_wr = !c;
		ctl_d = d[2:0];
		rl_d = d;
		@(negedge clk);
		ctl_wr = 1'b0;
		rl_wr = 1'b0;
	endtask : wr

	// bounded so a stuck pin cannot hang the run
	task automatic wait_sig(input logic sel, input logic lvl, output int cyc);
		cyc = 0;
		while ((sel ? run : pin) !== lvl && cyc < 3000) begin
			@(negedge clk);
			cyc++;
		end
		if (cyc >= 3000) begin
			mismatches++;
			stop_test();
		end
	endtask : wait_sig

	initial begin
		ctl_wr = 1'b0;
		rl_wr = 1'b0;
		ufl = 1'b0;
		port = 1'b0;
		clr = 1'b0;
		ctl_d = 3'h0;
		rl_d = 8'h00;
		rst = 1'b1;
		seed = 16'h4558;
		mismatches = 0;
		samples_checked = 0;
		repeat (5) @(negedge clk);
		chk({4'h0, pin, run, mid, high, cnt}, 16'h0000);
		rst = 1'b0;
		repeat (8) begin
			seed = lfsr(seed);
			port = seed[0];
			@(negedge clk);
			chk({15'h0, pin}, {15'h0, port});
		end
		$display("io test done");
		port = 1'b0;
		rl = int'(seed[3:1]) + 1;
		wr(1'b0, 8'(rl));
		wr(1'b1, 8'h01);
		chk({7'h0, run, cnt}, {7'h0, 1'b1, 8'(rl)});
		chk({15'h0, pin}, 16'h0000);
		// first half period may be short, tick phase is free
		wait_sig(1'b0, !pin, n);
		repeat (4) begin
			wait_sig(1'b0, !pin, n);
			chk(16'(n), 16'((rl + 1) * 10));
		end
		wr(1'b1, 8'h00);
		repeat (40) begin
			@(negedge clk);
			chk({7'h0, run, 7'h0, pin}, 16'h0000);
		end
		$display("square test done");
		wr(1'b1, 8'h02);
		repeat (2) begin
			ufl = 1'b1;
			@(negedge clk);
			ufl = 1'b0;
			chk({6'h0, run, pin, cnt}, {6'h0, 2'b11, 8'(rl)});
			wait_sig(1'b0, 1'b0, n);
			chk(16'(n >= rl * 10 + 2 && n <= (rl + 1) * 10 + 1), 16'h0001);
			repeat (30) @(negedge clk);
			chk({7'h0, run, 7'h0, pin}, 16'h0000);
		end
		$display("duty test done");
		for (int m = 0; m < 2; m++) begin
			clr = 1'b1;
			@(negedge clk);
			clr = 1'b0;
			wr(1'b1, (m == 1) ? 8'h05 : 8'h07);
			chk({13'h0, high, mid, run}, (m == 1) ? 16'h0005 : 16'h0007);
			wait_sig(1'b1, 1'b0, n);
			repeat (20) @(negedge clk);
			chk(16'(rises == rl + 1 || (m == 1 && rises == rl)), 16'h0001);
			chk({7'h0, run, 7'h0, pin}, 16'h0000);
		end
		$display("burst test done");
		stop_test();
	end
endmodule : tb
`default_nettype wire
